// *** core/brc_top.sv ***
// bridge interrupt and control register with apb access and side effects
`timescale 1ns/1ps
module brc_top
  import brc_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        power_good_reset_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // command register enables and mode
  input  wire logic        cmd_serr_en_i,
  input  wire logic        pcix_mode_i,
  input  wire logic        discard_run_i,
  input  wire logic        hotplug_enable_i,
  input  wire logic        hotplug_event_i,
  // system error inputs
  input  wire logic        secondary_syserr_n_i,
  input  wire logic        hotplug_syserr_i,
  // parity
  input  wire logic        parity_detect_i,
  input  wire logic        secondary_parity_err_n_i,
  input  wire logic        parity_drive_req_i,
  output logic             secondary_parity_err_n_o,
  output logic             secondary_parity_err_oe_n_o,
  // master abort reporting
  input  wire logic        mabort_i,
  input  wire logic        mabort_posted_i,
  input  wire logic        mabort_read_i,
  output brc_abort_t       abort_action_o,
  output logic [31:0]      abort_rdata_o,
  // decode
  input  wire brc_req_t    host_req_i,
  input  wire brc_io_win_t io_win_i,
  output logic             vga_hit_o,
  output logic             io_hit_o,
  // outputs to link and bus
  output logic             secondary_reset_n_o,
  output logic             sync_flood_o,
  output logic             signaled_system_error_o,
  output logic             bridge_irq_a_n_o
);
  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire access   = psel_i && penable_i;
  wire hit_ctrl = (paddr_i == BRC_OFF_BRIDGE_CTRL);
  wire hit_stat = (paddr_i == BRC_OFF_STATUS);
  wire wr_ctrl  = access && pwrite_i && hit_ctrl;
  wire wr_stat  = access && pwrite_i && hit_stat;

  assign pready_o  = 1'b1;
  assign pslverr_o = access && !(hit_ctrl || hit_stat);

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  brc_ctrl_t ctrl_reg;
  brc_ctrl_t ctrl_next;
  logic      secrst_reg;
  logic      rse_reg;
  logic      master_data_parity_error_reg;
  logic      sse_reg;
  logic      flood_reg;
  logic [31:0] prdata_reg;
  brc_abort_t  abort_reg;
  logic [31:0] abort_rdata_reg;
  logic        dt_status;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next.flood_en  = pwdata_i[BRC_B_FLOOD_EN];
      ctrl_next.abort_sel = pwdata_i[BRC_B_ABORTSEL];
      ctrl_next.vga_en    = pwdata_i[BRC_B_VGA_DECODE_ENABLE];
      ctrl_next.isa_en    = pwdata_i[BRC_B_ISA_DECODE_ENABLE];
      ctrl_next.serr_en   = pwdata_i[BRC_B_SYSTEM_ERROR_ENABLE];
      ctrl_next.perr_en   = pwdata_i[BRC_B_PARITY_RESPONSE_ENABLE];
      ctrl_next.irq_line  = pwdata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ctrl_reg   <= '0;
      secrst_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_ctrl) begin
        secrst_reg <= pwdata_i[BRC_B_SECRST];
      end
    end
  end

  assign secondary_reset_n_o = !secrst_reg;

  // ---------------------------------------------------------------
  // discard timer
  // ---------------------------------------------------------------
  brc_discard_timer u_dt (
    .mclk_i      (mclk_i),
    .power_good_reset_n_i   (power_good_reset_n_i),
    .run_i       (discard_run_i),
    .pcix_mode_i (pcix_mode_i),
    .clear_i     (wr_ctrl && pwdata_i[BRC_B_DTSTAT]),
    .status_o    (dt_status)
  );

  // ---------------------------------------------------------------
  // error status, survives system reset
  // ---------------------------------------------------------------
  wire serr_in   = !secondary_syserr_n_i || hotplug_syserr_i;
  wire serr_both = cmd_serr_en_i && ctrl_reg.serr_en;
  wire flood_dt  = ctrl_reg.flood_en && cmd_serr_en_i && dt_status;
  wire flood_se  = serr_both && rse_reg;
  wire perr_seen = parity_detect_i || !secondary_parity_err_n_i;
  wire master_data_parity_error_set  = ctrl_reg.perr_en && perr_seen;
  wire posted_ab = mabort_i && mabort_posted_i && ctrl_reg.abort_sel;
  wire sse_set   = flood_dt || flood_se || posted_ab;

  always_ff @(posedge mclk_i) begin
    if (!power_good_reset_n_i) begin
      rse_reg   <= 1'b0;
      master_data_parity_error_reg  <= 1'b0;
      sse_reg   <= 1'b0;
      flood_reg <= 1'b0;
    end else begin
      if (serr_in) begin
        rse_reg <= 1'b1;
      end else if (wr_stat && pwdata_i[BRC_B_RSE]) begin
        rse_reg <= 1'b0;
      end
      if (master_data_parity_error_set) begin
        master_data_parity_error_reg <= 1'b1;
      end else if (wr_stat && pwdata_i[BRC_B_MASTER_DATA_PARITY_ERROR]) begin
        master_data_parity_error_reg <= 1'b0;
      end
      if (sse_set) begin
        sse_reg <= 1'b1;
      end
      if (flood_dt || flood_se) begin
        flood_reg <= 1'b1;
      end
    end
  end

  assign sync_flood_o            = flood_reg;
  assign signaled_system_error_o = sse_reg;

  // parity pin driven only when enabled
  assign secondary_parity_err_n_o    = 1'b0;
  assign secondary_parity_err_oe_n_o = !(ctrl_reg.perr_en && parity_drive_req_i);

  // ---------------------------------------------------------------
  // master abort response
  // ---------------------------------------------------------------
  wire brc_abort_t abort_next = !mabort_i ? BRC_ABORT_NONE :
                                ctrl_reg.abort_sel ? BRC_ABORT_TARGET :
                                mabort_read_i ? BRC_ABORT_ONES : BRC_ABORT_DROP;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      abort_reg       <= BRC_ABORT_NONE;
      abort_rdata_reg <= '0;
    end else begin
      abort_reg       <= abort_next;
      abort_rdata_reg <= (abort_next == BRC_ABORT_ONES) ? BRC_ALL_ONES : '0;
    end
  end
  assign abort_action_o = abort_reg;
  assign abort_rdata_o  = abort_rdata_reg;

  // ---------------------------------------------------------------
  // decode and interrupt
  // ---------------------------------------------------------------
  brc_decode u_dec (
    .req_i     (host_req_i),
    .vga_en_i  (ctrl_reg.vga_en),
    .isa_en_i  (ctrl_reg.isa_en),
    .win_i     (io_win_i),
    .vga_hit_o (vga_hit_o),
    .io_hit_o  (io_hit_o)
  );

  assign bridge_irq_a_n_o = !(hotplug_enable_i && hotplug_event_i);

  // ---------------------------------------------------------------
  // read data, reserved bits zero
  // ---------------------------------------------------------------
  wire [7:0]  irq_pin = hotplug_enable_i ? BRC_IRQ_PIN_ON : 8'h00;
  wire [31:0] ctrl_rd = {4'h0, ctrl_reg.flood_en, dt_status, 3'h0, secrst_reg, ctrl_reg.abort_sel,
                         1'b0, ctrl_reg.vga_en, ctrl_reg.isa_en, ctrl_reg.serr_en, ctrl_reg.perr_en,
                         irq_pin, ctrl_reg.irq_line};
  wire [31:0] stat_rd = {30'h0, master_data_parity_error_reg, rse_reg};
  wire [31:0] rd_next = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : 32'h0000_0000;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      prdata_reg <= '0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_reg <= rd_next;
    end
  end
  assign prdata_o = prdata_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_secrst_follow: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    wr_ctrl |=> secondary_reset_n_o == !$past(pwdata_i[BRC_B_SECRST]))
    else $error("secondary reset pin wrong");
  a_flood_dt_sse: assert property (@(posedge mclk_i) disable iff (!power_good_reset_n_i)
    flood_dt |=> sse_reg && flood_reg) else $error("discard flood missed");
  a_serr_flood: assert property (@(posedge mclk_i) disable iff (!power_good_reset_n_i)
    serr_in && serr_both ##1 serr_both |=> flood_reg && sse_reg) else $error("system error flood missed");
  a_serr_masked: assert property (@(posedge mclk_i) disable iff (!power_good_reset_n_i)
    !serr_both && !posted_ab && !flood_dt && !sse_reg |=> !sse_reg) else $error("sse set while masked");
  a_rse_sticky: assert property (@(posedge mclk_i) disable iff (!power_good_reset_n_i)
    serr_in |=> rse_reg) else $error("received error not held");
  a_master_data_parity_error_block: assert property (@(posedge mclk_i) disable iff (!power_good_reset_n_i)
    !ctrl_reg.perr_en && !master_data_parity_error_reg |=> !master_data_parity_error_reg) else $error("parity status set while disabled");
  a_abort_target: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    mabort_i && ctrl_reg.abort_sel |=> abort_action_o == BRC_ABORT_TARGET) else $error("target abort missing");
  a_abort_ones: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    mabort_i && mabort_read_i && !ctrl_reg.abort_sel |=> abort_rdata_o == BRC_ALL_ONES) else $error("ones data missing");
  a_irq_pin_val: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    psel_i && !penable_i && !pwrite_i && hit_ctrl |=> prdata_o[15:8] == {7'h00, $past(hotplug_enable_i)})
    else $error("interrupt pin value wrong");
  c_flood_dt: cover property (@(posedge mclk_i) disable iff (!power_good_reset_n_i) flood_dt);
  c_serr_flood: cover property (@(posedge mclk_i) disable iff (!power_good_reset_n_i) flood_se);
  c_abort_drop: cover property (@(posedge mclk_i) disable iff (!resetn_i) abort_action_o == BRC_ABORT_DROP);
  c_vga_hit: cover property (@(posedge mclk_i) vga_hit_o);
endmodule

// *** core/brc_pkg.sv ***
// constants and types for the bridge interrupt and control register
package brc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] BRC_OFF_BRIDGE_CTRL = 12'h03C;
  localparam logic [11:0] BRC_OFF_STATUS      = 12'h040;
  localparam logic [31:0] BRC_BRIDGE_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] BRC_BRIDGE_CTRL_WM  = 32'h086F_00FF;
  localparam logic [31:0] BRC_STATUS_WM       = 32'h0000_0003;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BRC_B_FLOOD_EN = 27;
  localparam int BRC_B_DTSTAT   = 26;
  localparam int BRC_B_SECRST   = 22;
  localparam int BRC_B_ABORTSEL = 21;
  localparam int BRC_B_VGA_DECODE_ENABLE    = 19;
  localparam int BRC_B_ISA_DECODE_ENABLE    = 18;
  localparam int BRC_B_SYSTEM_ERROR_ENABLE   = 17;
  localparam int BRC_B_PARITY_RESPONSE_ENABLE    = 16;
  localparam int BRC_B_RSE      = 0;
  localparam int BRC_B_MASTER_DATA_PARITY_ERROR     = 1;
  // ---------------------------------------------------------------
  // decode constants and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] BRC_VGA_MEM_LO = 32'h000A_0000;
  localparam logic [31:0] BRC_VGA_MEM_HI = 32'h000B_FFFF;
  localparam logic [9:0]  BRC_VGA_IO1_LO = 10'h3B0;
  localparam logic [9:0]  BRC_VGA_IO1_HI = 10'h3BB;
  localparam logic [9:0]  BRC_VGA_IO2_LO = 10'h3C0;
  localparam logic [9:0]  BRC_VGA_IO2_HI = 10'h3DF;
  localparam int          BRC_DT_WIDTH   = 15;
  localparam logic [7:0]  BRC_IRQ_PIN_ON = 8'h01;
  localparam logic [31:0] BRC_ALL_ONES   = 32'hFFFF_FFFF;

  typedef struct packed {
    logic        flood_en;
    logic        abort_sel;
    logic        vga_en;
    logic        isa_en;
    logic        serr_en;
    logic        perr_en;
    logic [7:0]  irq_line;
  } brc_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [31:0] addr;
  } brc_req_t;

  typedef struct packed {
    logic [15:0] io_base;
    logic [15:0] io_base_hi;
    logic [15:0] io_limit;
    logic [15:0] io_limit_hi;
  } brc_io_win_t;

  typedef enum logic [1:0] {
    BRC_ABORT_NONE   = 2'b00,
    BRC_ABORT_TARGET = 2'b01,
    BRC_ABORT_ONES   = 2'b10,
    BRC_ABORT_DROP   = 2'b11
  } brc_abort_t;
endpackage

// *** core/brc_discard_timer.sv ***
// 15-bit discard timer with status flag held across system reset
`timescale 1ns/1ps
module brc_discard_timer
  import brc_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic power_good_reset_n_i,
  input  wire logic run_i,
  input  wire logic pcix_mode_i,
  input  wire logic clear_i,
  output logic      status_o
);
  logic [BRC_DT_WIDTH-1:0] count_reg;
  logic                    status_reg;
  wire                     expire = run_i && (&count_reg);
  wire                     set_ev = expire && !pcix_mode_i;

  always_ff @(posedge mclk_i) begin
    if (!power_good_reset_n_i || !run_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // power-good and software clear both clear; set beats software clear
  always_ff @(posedge mclk_i) begin
    if (!power_good_reset_n_i) begin
      status_reg <= 1'b0;
    end else if (set_ev) begin
      status_reg <= 1'b1;
    end else if (clear_i) begin
      status_reg <= 1'b0;
    end
  end
  assign status_o = status_reg;

  a_dt_pcix_block: assert property (@(posedge mclk_i) disable iff (!power_good_reset_n_i)
    pcix_mode_i && !status_reg |=> !status_reg) else $error("timeout status set in pcix mode");
  a_dt_expire_set: assert property (@(posedge mclk_i) disable iff (!power_good_reset_n_i)
    set_ev |=> status_reg) else $error("timeout status missed expiry");
endmodule

// *** core/brc_decode.sv ***
// vga and isa address decode for host-initiated accesses
`timescale 1ns/1ps
module brc_decode
  import brc_pkg::*;
(
  input  wire brc_req_t    req_i,
  input  wire logic        vga_en_i,
  input  wire logic        isa_en_i,
  input  wire brc_io_win_t win_i,
  output logic             vga_hit_o,
  output logic             io_hit_o
);
  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  wire [31:0] base32  = {win_i.io_base_hi, win_i.io_base};
  wire [31:0] limit32 = {win_i.io_limit_hi, win_i.io_limit};
  wire        low64k  = (req_i.addr[31:16] == 16'h0000);
  wire [31:0] lo10    = {22'h0, req_i.addr[9:0]};
  wire        vga_mem = in_range(req_i.addr, BRC_VGA_MEM_LO, BRC_VGA_MEM_HI);
  wire        vga_io  = low64k && (in_range(lo10, {22'h0, BRC_VGA_IO1_LO}, {22'h0, BRC_VGA_IO1_HI}) ||
                                   in_range(lo10, {22'h0, BRC_VGA_IO2_LO}, {22'h0, BRC_VGA_IO2_HI}));
  wire        in_win  = in_range(req_i.addr, base32, limit32);
  wire        isa_cut = isa_en_i && low64k && (req_i.addr[9:8] != 2'b00);

  assign vga_hit_o = req_i.valid && vga_en_i && (req_i.is_io ? vga_io : vga_mem);
  assign io_hit_o  = req_i.valid && req_i.is_io && in_win && !isa_cut;
endmodule

// *** verification/brc_sec_agent.sv ***
// secondary bus agent model: system error and parity error lines
`timescale 1ns/1ps
module brc_sec_agent (
  input  wire logic mclk_i,
  input  wire logic serr_req_i,
  input  wire logic perr_req_i,
  input  wire logic perr_dut_n_i,
  input  wire logic perr_dut_oe_n_i,
  output logic      syserr_n_o,
  output logic      perr_line_n_o
);
  initial syserr_n_o = 1'b1;
  always @(posedge mclk_i) syserr_n_o <= !serr_req_i;
  // pulled-up shared line: released means high
  assign perr_line_n_o = (perr_dut_oe_n_i ? 1'b1 : perr_dut_n_i) & !perr_req_i;
endmodule

// *** verification/tb_bridge_control_register.sv ***
// self-checking bench for the bridge interrupt and control register
`timescale 1ns/1ps
module tb_bridge_control_register
  import brc_pkg::*;
;
  logic        mclk_i, resetn_i, power_good_reset_n_i, psel_i, penable_i, pwrite_i, err;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, abort_rdata_o, rd;
  logic        pready_o, pslverr_o, cmd_serr_en_i, pcix_mode_i, discard_run_i;
  logic        hotplug_enable_i, hotplug_event_i, syserr_n, hotplug_syserr_i;
  logic        parity_detect_i, perr_line_n, parity_drive_req_i, perr_n, perr_oe_n;
  logic        mabort_i, mabort_posted_i, mabort_read_i, vga_hit_o, io_hit_o;
  logic        sec_rst_n, sync_flood_o, signaled_system_error, irq_a_n, serr_req, perr_req;
  brc_abort_t  abort_action_o;
  brc_req_t    host_req_i;
  brc_io_win_t io_win_i;
  int          bad_count, num_checks;

  brc_top DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .power_good_reset_n_i(power_good_reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cmd_serr_en_i(cmd_serr_en_i),
    .pcix_mode_i(pcix_mode_i), .discard_run_i(discard_run_i), .hotplug_enable_i(hotplug_enable_i),
    .hotplug_event_i(hotplug_event_i), .secondary_syserr_n_i(syserr_n), .hotplug_syserr_i(hotplug_syserr_i),
    .parity_detect_i(parity_detect_i), .secondary_parity_err_n_i(perr_line_n),
    .parity_drive_req_i(parity_drive_req_i), .secondary_parity_err_n_o(perr_n),
    .secondary_parity_err_oe_n_o(perr_oe_n), .mabort_i(mabort_i), .mabort_posted_i(mabort_posted_i),
    .mabort_read_i(mabort_read_i), .abort_action_o(abort_action_o), .abort_rdata_o(abort_rdata_o),
    .host_req_i(host_req_i), .io_win_i(io_win_i), .vga_hit_o(vga_hit_o), .io_hit_o(io_hit_o),
    .secondary_reset_n_o(sec_rst_n), .sync_flood_o(sync_flood_o), .signaled_system_error_o(signaled_system_error),
    .bridge_irq_a_n_o(irq_a_n));

  brc_sec_agent agent (.mclk_i(mclk_i), .serr_req_i(serr_req), .perr_req_i(perr_req),
    .perr_dut_n_i(perr_n), .perr_dut_oe_n_i(perr_oe_n), .syserr_n_o(syserr_n), .perr_line_n_o(perr_line_n));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdchk(string what, logic [11:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task automatic dec(logic io, logic [31:0] a, logic ev, logic eh);
    host_req_i <= '{1'b1, io, a};
    cyc(1);
    chk("vga hit", {31'h0, vga_hit_o}, {31'h0, ev});
    chk("io hit", {31'h0, io_hit_o}, {31'h0, eh});
  endtask

  task automatic ab(logic p, logic r, brc_abort_t ea, logic [31:0] ed);
    mabort_i <= 1'b1;
    mabort_posted_i <= p;
    mabort_read_i <= r;
    cyc(1);
    mabort_i <= 1'b0;
    // sample mid-cycle while the one-cycle answer stands
    @(negedge mclk_i);
    chk("abort action", {30'h0, abort_action_o}, {30'h0, ea});
    chk("abort data", abort_rdata_o, ed);
    cyc(1);
  endtask

  task automatic power_good_reset_pulse;
    power_good_reset_n_i <= 1'b0;
    cyc(1);
    power_good_reset_n_i <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  initial begin
    #1800000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    {resetn_i, power_good_reset_n_i, psel_i, penable_i, pwrite_i, cmd_serr_en_i, pcix_mode_i} = '0;
    {discard_run_i, hotplug_enable_i, hotplug_event_i, hotplug_syserr_i, serr_req, perr_req} = '0;
    {parity_detect_i, parity_drive_req_i, mabort_i, mabort_posted_i, mabort_read_i} = '0;
    {paddr_i, pwdata_i, host_req_i} = '0;
    io_win_i = '{16'h1000, 16'h0000, 16'h1FFF, 16'h0000};
    bad_count = 0;
    num_checks = 0;
    cyc(10);
    resetn_i <= 1'b1;
    power_good_reset_n_i <= 1'b1;
    rdchk("ctrl reset", 12'h03C, 32'h0);
    apb(1'b1, 12'h03C, 32'hFFFF_FFFF);
    rdchk("ctrl all ones", 12'h03C, 32'h086F_00FF);
    chk("sec reset on", {31'h0, sec_rst_n}, 32'h0);
    apb(1'b1, 12'h03C, 32'h0000_005A);
    cyc(20);
    chk("sec reset off", {31'h0, sec_rst_n}, 32'h1);
    rdchk("irq line", 12'h03C, 32'h0000_005A);
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    chk("unmapped err", {31'h0, err}, 32'h1);
    rdchk("unmapped read", 12'h100, 32'h0);
    hotplug_enable_i <= 1'b1;
    hotplug_event_i <= 1'b1;
    rdchk("irq pin on", 12'h03C, 32'h0000_015A);
    chk("irq a on", {31'h0, irq_a_n}, 32'h0);
    hotplug_enable_i <= 1'b0;
    rdchk("irq pin off", 12'h03C, 32'h0000_005A);
    chk("irq a off", {31'h0, irq_a_n}, 32'h1);
    apb(1'b1, 12'h03C, 32'h000C_0000);
    dec(1'b0, 32'h000A_0000, 1'b1, 1'b0);
    dec(1'b0, 32'h000B_FFFF, 1'b1, 1'b0);
    dec(1'b0, 32'h000C_0000, 1'b0, 1'b0);
    dec(1'b0, 32'h001A_0000, 1'b0, 1'b0);
    dec(1'b1, 32'h0000_03B0, 1'b1, 1'b0);
    dec(1'b1, 32'h0000_03BC, 1'b0, 1'b0);
    dec(1'b1, 32'h0000_07DF, 1'b1, 1'b0);
    dec(1'b1, 32'h0001_03C0, 1'b0, 1'b0);
    dec(1'b1, 32'h0000_10FF, 1'b0, 1'b1);
    dec(1'b1, 32'h0000_1100, 1'b0, 1'b0);
    apb(1'b1, 12'h03C, 32'h0);
    dec(1'b0, 32'h000A_0000, 1'b0, 1'b0);
    dec(1'b1, 32'h0000_03C0, 1'b0, 1'b0);
    dec(1'b1, 32'h0000_1100, 1'b0, 1'b1);
    ab(1'b0, 1'b1, BRC_ABORT_ONES, BRC_ALL_ONES);
    ab(1'b1, 1'b0, BRC_ABORT_DROP, 32'h0);
    apb(1'b1, 12'h03C, 32'h0020_0000);
    ab(1'b0, 1'b1, BRC_ABORT_TARGET, 32'h0);
    ab(1'b0, 1'b0, BRC_ABORT_TARGET, 32'h0);
    chk("sse before posted", {31'h0, signaled_system_error}, 32'h0);
    mabort_i <= 1'b1;
    mabort_posted_i <= 1'b1;
    cyc(1);
    mabort_i <= 1'b0;
    cyc(3);
    chk("sse posted abort", {31'h0, signaled_system_error}, 32'h1);
    power_good_reset_pulse();
    apb(1'b1, 12'h03C, 32'h0002_0000);
    serr_req <= 1'b1;
    cyc(2);
    rdchk("rse set", 12'h040, 32'h1);
    chk("no flood", {31'h0, sync_flood_o}, 32'h0);
    chk("no sse", {31'h0, signaled_system_error}, 32'h0);
    apb(1'b1, 12'h040, 32'h1);
    rdchk("rse held", 12'h040, 32'h1);
    cmd_serr_en_i <= 1'b1;
    cyc(4);
    chk("serr flood", {31'h0, sync_flood_o}, 32'h1);
    chk("serr sse", {31'h0, signaled_system_error}, 32'h1);
    serr_req <= 1'b0;
    cmd_serr_en_i <= 1'b0;
    cyc(3);
    apb(1'b1, 12'h040, 32'h1);
    rdchk("rse cleared", 12'h040, 32'h0);
    hotplug_syserr_i <= 1'b1;
    rdchk("rse hotplug", 12'h040, 32'h1);
    hotplug_syserr_i <= 1'b0;
    apb(1'b1, 12'h040, 32'h1);
    power_good_reset_pulse();
    apb(1'b1, 12'h03C, 32'h0);
    parity_detect_i <= 1'b1;
    parity_drive_req_i <= 1'b1;
    perr_req <= 1'b1;
    rdchk("no parity status", 12'h040, 32'h0);
    chk("parity undriven", {31'h0, perr_oe_n}, 32'h1);
    perr_req <= 1'b0;
    apb(1'b1, 12'h03C, 32'h0001_0000);
    rdchk("parity status", 12'h040, 32'h2);
    chk("parity driven", {31'h0, perr_line_n}, 32'h0);
    parity_detect_i <= 1'b0;
    parity_drive_req_i <= 1'b0;
    apb(1'b1, 12'h040, 32'h2);
    discard_run_i <= 1'b1;
    pcix_mode_i <= 1'b1;
    cyc(33000);
    rdchk("no timeout pcix", 12'h03C, 32'h0001_0000);
    discard_run_i <= 1'b0;
    pcix_mode_i <= 1'b0;
    cyc(1);
    discard_run_i <= 1'b1;
    cyc(32700);
    rdchk("timer running", 12'h03C, 32'h0001_0000);
    cyc(100);
    discard_run_i <= 1'b0;
    rdchk("timer expired", 12'h03C, 32'h0401_0000);
    resetn_i <= 1'b0;
    cyc(1);
    resetn_i <= 1'b1;
    rdchk("status kept", 12'h03C, 32'h0400_0000);
    chk("flood idle", {31'h0, sync_flood_o}, 32'h0);
    cmd_serr_en_i <= 1'b1;
    apb(1'b1, 12'h03C, 32'h0800_0000);
    cyc(4);
    chk("timeout flood", {31'h0, sync_flood_o}, 32'h1);
    chk("timeout sse", {31'h0, signaled_system_error}, 32'h1);
    apb(1'b1, 12'h03C, 32'h0400_0000);
    rdchk("timeout cleared", 12'h03C, 32'h0);
    tally_and_finish();
  end
endmodule
